// File: hdl/tlhp_top.sv
// Tile prefetchers: L1 stride engine, L2 stream detectors and software prefetch handling.
`timescale 1ns/1ps
module tlhp_top
  import tlhp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Data-cache access observation
  input wire logic acc_valid_i,
  input wire logic [PA_W-1:0] acc_addr_i,
  input wire logic [PA_W-1:0] acc_ip_i,
  input wire logic [LP_W-1:0] acc_lp_i,
  input wire logic acc_cacheable_i,
  // L2 access observation
  input wire logic l2_acc_valid_i,
  input wire logic [LN_W-1:0] l2_acc_line_i,
  // L1 presence probe
  output logic [LN_W-1:0] l1_probe_line_o,
  input wire logic l1_line_present_i,
  // L1 fill requests and completions
  output logic l1_fill_valid_o,
  output logic [LN_W-1:0] l1_fill_line_o,
  input wire logic l1_fill_ready_i,
  input wire logic l1_fill_done_i,
  input wire logic [LN_W-1:0] l1_fill_done_line_i,
  // L2 prefetch lookup
  output logic l2_pf_valid_o,
  output logic [LN_W-1:0] l2_pf_line_o,
  input wire logic l2_pf_ready_i,
  input wire logic l2_resp_valid_i,
  input wire logic l2_resp_miss_i,
  // Memory prefetch requests
  output logic mem_pf_valid_o,
  output logic [LN_W-1:0] mem_pf_line_o,
  input wire logic mem_pf_ready_i,
  // Software prefetch requests
  input wire logic swpf_valid_i,
  input wire logic [PA_W-1:0] swpf_addr_i,
  input wire logic swpf_l1_i,
  output logic swpf_ready_o,
  // Page table walker
  output logic walk_req_o,
  output logic [PA_W-1:0] walk_addr_o,
  input wire logic walk_done_i
);
  // ---------------------------------------------------------------
  // Per-core stride prefetcher
  // ---------------------------------------------------------------
  logic [ST_DEPTH-1:0] st_vld_ff;
  logic s1_v_ff;
  logic s1_cach_ff;
  logic [PA_W-1:0] s1_addr_ff;
  logic [ST_IDX_W-1:0] s1_idx_ff;
  logic s1_byp_ff;
  tlhp_stride_t s1_byp_d_ff;
  tlhp_stride_t rd_ent;
  tlhp_stride_t wr_ent;
  logic cand_v_ff;
  logic [LN_W-1:0] cand_line_ff;

  wire [ST_IDX_W-1:0] rd_idx = acc_ip_i[ST_IDX_W-1:0]
                               ^ {acc_lp_i, {(ST_IDX_W-LP_W){1'b0}}};
  wire st_wr = s1_v_ff;
  wire tlhp_stride_t ent = s1_byp_ff ? s1_byp_d_ff : rd_ent;
  wire ent_vld = st_vld_ff[s1_idx_ff];
  wire [PA_W:0] diff = {1'b0, s1_addr_ff} - {1'b0, ent.last};
  wire fits = ent_vld && ((&diff[PA_W:STRIDE_W-1]) | ~(|diff[PA_W:STRIDE_W-1]));
  wire [STRIDE_W-1:0] new_stride = fits ? diff[STRIDE_W-1:0] : '0;
  wire same = ent_vld && fits && (new_stride == ent.stride) && (new_stride != '0);
  wire [CONF_W-1:0] new_conf = !same ? CONF_RST
                             : (ent.conf == CONF_MAX) ? CONF_MAX : ent.conf + 2'h1;
  wire [PA_W-1:0] pred = s1_addr_ff
                         + {{(PA_W-STRIDE_W){new_stride[STRIDE_W-1]}}, new_stride};
  wire pred_in_page = pred[PA_W-1:PAGE_OFS] == s1_addr_ff[PA_W-1:PAGE_OFS];
  wire cand_load = st_wr && s1_cach_ff && same
                   && (new_conf >= CONF_TRAIN) && pred_in_page;

  assign wr_ent = '{last: s1_addr_ff, stride: new_stride, conf: new_conf};

  tlhp_stride_mem u_mem
  (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .rd_idx_i(rd_idx),
    .rd_data_o(rd_ent),
    .wr_en_i(st_wr),
    .wr_idx_i(s1_idx_ff),
    .wr_data_i(wr_ent)
  );

  // The array read returns stale data when the same entry is written in the
  // read cycle, so that write is captured and forwarded instead.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1_v_ff <= 1'b0;
      s1_cach_ff <= 1'b0;
      s1_addr_ff <= '0;
      s1_idx_ff <= '0;
      s1_byp_ff <= 1'b0;
      s1_byp_d_ff <= '0;
      st_vld_ff <= '0;
    end
    else
    begin
      s1_v_ff <= acc_valid_i;
      s1_cach_ff <= acc_cacheable_i;
      s1_addr_ff <= acc_addr_i;
      s1_idx_ff <= rd_idx;
      s1_byp_ff <= st_wr && (s1_idx_ff == rd_idx);
      s1_byp_d_ff <= wr_ent;
      if (st_wr)
        st_vld_ff[s1_idx_ff] <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // L1 fill port and fill buffers
  // ---------------------------------------------------------------
  tlhp_sw_t sw_st_ff;
  logic sw_l1_ff;
  logic [PA_W-1:0] sw_addr_ff;
  logic [FB_N-1:0] fb_v_ff;
  logic [LN_W-1:0] fb_line_ff [FB_N];
  logic [FB_N-1:0] fb_cand_hit;
  logic [FB_IDX_W-1:0] fb_free_idx;

  wire [LN_W-1:0] sw_line = sw_addr_ff[PA_W-1:LINE_OFS];
  wire sw_l1_req = (sw_st_ff == SW_ISSUE) && sw_l1_ff;
  wire fb_full = &fb_v_ff;
  wire cand_blocked = l1_line_present_i || (|fb_cand_hit);
  wire cand_drop = cand_v_ff && !sw_l1_req && cand_blocked;
  wire l1_fire = l1_fill_valid_o && l1_fill_ready_i;

  assign l1_probe_line_o = cand_line_ff;
  assign l1_fill_valid_o = !fb_full && (sw_l1_req || (cand_v_ff && !cand_blocked));
  assign l1_fill_line_o = sw_l1_req ? sw_line : cand_line_ff;

  always_comb
  begin
    fb_free_idx = '0;
    for (int i = FB_N - 1; i >= 0; i--)
    begin
      if (!fb_v_ff[i])
        fb_free_idx = FB_IDX_W'(i);
    end
  end

  // Every accepted L1 fill holds an entry until its completion returns.
  for (genvar gf = 0; gf < FB_N; gf++)
  begin : g_fb
    assign fb_cand_hit[gf] = fb_v_ff[gf] && (fb_line_ff[gf] == cand_line_ff);
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        fb_v_ff[gf] <= 1'b0;
        fb_line_ff[gf] <= '0;
      end
      else if (l1_fire && (fb_free_idx == FB_IDX_W'(gf)))
      begin
        fb_v_ff[gf] <= 1'b1;
        fb_line_ff[gf] <= l1_fill_line_o;
      end
      else if (l1_fill_done_i && (fb_line_ff[gf] == l1_fill_done_line_i))
        fb_v_ff[gf] <= 1'b0;
    end
  end

  // A fresh prediction replaces one still waiting; the newest is the most useful.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cand_v_ff <= 1'b0;
      cand_line_ff <= '0;
    end
    else if (cand_load)
    begin
      cand_v_ff <= 1'b1;
      cand_line_ff <= pred[PA_W-1:LINE_OFS];
    end
    else if (cand_drop || (l1_fire && !sw_l1_req))
      cand_v_ff <= 1'b0;
  end

  // ---------------------------------------------------------------
  // L2 stream detectors
  // ---------------------------------------------------------------
  logic [DET_N-1:0] det_v_ff;
  logic [PG_W-1:0] det_pg_ff [DET_N];
  logic [REG_W-1:0] det_last_ff [DET_N];
  logic [DET_N-1:0] det_dir_ff;
  logic [DET_N-1:0] det_step_ff;
  logic [DET_N-1:0] det_hit;
  logic [DET_N-1:0] det_fire;
  logic [REG_W-1:0] det_off_m [DET_N];
  logic [REG_W-1:0] stream_off;
  logic [DET_IDX_W-1:0] alloc_ptr_ff;

  wire [PG_W-1:0] acc_pg = l2_acc_line_i[LN_W-1:REG_W];
  wire [REG_W-1:0] acc_off = l2_acc_line_i[REG_W-1:0];
  wire det_alloc = l2_acc_valid_i && !(|det_hit);
  wire stream_fire = |det_fire;
  wire [LN_W-1:0] stream_line = {acc_pg, stream_off};

  for (genvar gd = 0; gd < DET_N; gd++)
  begin : g_det
    wire up = (det_last_ff[gd] != REG_TOP) && (acc_off == det_last_ff[gd] + REG_STEP);
    wire dn = (det_last_ff[gd] != REG_BOT) && (acc_off == det_last_ff[gd] - REG_STEP);
    wire edge_ok = up ? (acc_off != REG_TOP) : (acc_off != REG_BOT);
    assign det_hit[gd] = l2_acc_valid_i && det_v_ff[gd]
                         && (det_pg_ff[gd] == acc_pg);
    assign det_fire[gd] = det_hit[gd] && (up || dn) && det_step_ff[gd]
                          && (det_dir_ff[gd] == up) && edge_ok;
    assign det_off_m[gd] = !det_fire[gd] ? REG_BOT
                         : up ? acc_off + REG_STEP : acc_off - REG_STEP;
    // Any step other than one line breaks the run, which is how interleaved
    // patterns in a region end up unrecognised.
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        det_v_ff[gd] <= 1'b0;
        det_pg_ff[gd] <= '0;
        det_last_ff[gd] <= REG_BOT;
        det_dir_ff[gd] <= 1'b0;
        det_step_ff[gd] <= 1'b0;
      end
      else if (det_hit[gd])
      begin
        det_step_ff[gd] <= up || dn;
        det_dir_ff[gd] <= (up || dn) ? up : det_dir_ff[gd];
        det_last_ff[gd] <= acc_off;
      end
      else if (det_alloc && (alloc_ptr_ff == DET_IDX_W'(gd)))
      begin
        det_v_ff[gd] <= 1'b1;
        det_pg_ff[gd] <= acc_pg;
        det_last_ff[gd] <= acc_off;
        det_step_ff[gd] <= 1'b0;
      end
    end
  end

  always_comb
  begin
    stream_off = REG_BOT;
    for (int i = 0; i < DET_N; i++)
      stream_off = stream_off | det_off_m[i];
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      alloc_ptr_ff <= DET_PTR_RST;
    else if (det_alloc)
      alloc_ptr_ff <= (alloc_ptr_ff == DET_PTR_LAST) ? DET_PTR_RST
                                                     : alloc_ptr_ff + 6'h01;
  end

  // ---------------------------------------------------------------
  // L2 prefetch path with memory forwarding
  // ---------------------------------------------------------------
  tlhp_l2_t l2_st_ff;
  logic [LN_W-1:0] l2_line_ff;

  wire sw_l2_take = (sw_st_ff == SW_ISSUE) && !sw_l1_ff && (l2_st_ff == L2_IDLE);

  assign l2_pf_valid_o = l2_st_ff == L2_LOOK;
  assign l2_pf_line_o = l2_line_ff;
  assign mem_pf_valid_o = l2_st_ff == L2_MEM;
  assign mem_pf_line_o = l2_line_ff;

  // Stream prefetches arriving while one is in flight are dropped, not queued.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      l2_st_ff <= L2_IDLE;
      l2_line_ff <= '0;
    end
    else
    begin
      unique case (l2_st_ff)
        L2_IDLE:
          if (sw_l2_take)
          begin
            l2_st_ff <= L2_LOOK;
            l2_line_ff <= sw_line;
          end
          else if (stream_fire)
          begin
            l2_st_ff <= L2_LOOK;
            l2_line_ff <= stream_line;
          end
        L2_LOOK:
          if (l2_pf_ready_i)
            l2_st_ff <= L2_WAIT;
        L2_WAIT:
          if (l2_resp_valid_i)
            l2_st_ff <= l2_resp_miss_i ? L2_MEM : L2_IDLE;
        L2_MEM:
          if (mem_pf_ready_i)
            l2_st_ff <= L2_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Software prefetch sequencing
  // ---------------------------------------------------------------
  assign swpf_ready_o = sw_st_ff == SW_IDLE;
  assign walk_req_o = sw_st_ff == SW_WALK;
  assign walk_addr_o = sw_addr_ff;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sw_st_ff <= SW_IDLE;
      sw_l1_ff <= 1'b0;
      sw_addr_ff <= '0;
    end
    else
    begin
      unique case (sw_st_ff)
        SW_IDLE:
          if (swpf_valid_i)
          begin
            sw_st_ff <= SW_WALK;
            sw_l1_ff <= swpf_l1_i;
            sw_addr_ff <= swpf_addr_i;
          end
        SW_WALK:
          if (walk_done_i)
            sw_st_ff <= SW_ISSUE;
        SW_ISSUE:
          if ((sw_l1_ff && l1_fire) || sw_l2_take)
            sw_st_ff <= SW_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_l1_same_page;
    @(posedge clk_sys_i) disable iff (rst_i)
    cand_load |=> cand_line_ff[LN_W-1:REG_W] == $past(s1_addr_ff[PA_W-1:PAGE_OFS]);
  endproperty
  a_l1_same_page: assert property (p_l1_same_page)
    else $error("Stride prefetch left its page.");

  property p_cacheable;
    @(posedge clk_sys_i) disable iff (rst_i)
    $rose(cand_v_ff) |-> $past(s1_cach_ff) && $past(s1_v_ff);
  endproperty
  a_cacheable: assert property (p_cacheable)
    else $error("Stride prefetch raised from a non-cacheable access.");

  property p_stream_step;
    @(posedge clk_sys_i) disable iff (rst_i)
    stream_fire |-> (stream_line == l2_acc_line_i + 34'h1)
                    || (stream_line == l2_acc_line_i - 34'h1);
  endproperty
  a_stream_step: assert property (p_stream_step)
    else $error("Stream prefetch is not the adjacent line.");

  property p_stream_region;
    @(posedge clk_sys_i) disable iff (rst_i)
    stream_fire |-> stream_line[LN_W-1:REG_W] == acc_pg;
  endproperty
  a_stream_region: assert property (p_stream_region)
    else $error("Stream prefetch crossed its region.");

  property p_ptr_range;
    @(posedge clk_sys_i) disable iff (rst_i)
    det_alloc |=> alloc_ptr_ff <= DET_PTR_LAST && alloc_ptr_ff != $past(alloc_ptr_ff);
  endproperty
  a_ptr_range: assert property (p_ptr_range)
    else $error("Detector pointer out of the pool.");

  property p_miss_to_mem;
    @(posedge clk_sys_i) disable iff (rst_i)
    (l2_st_ff == L2_WAIT && l2_resp_valid_i && l2_resp_miss_i)
      |=> mem_pf_valid_o && (mem_pf_line_o == $past(l2_pf_line_o));
  endproperty
  a_miss_to_mem: assert property (p_miss_to_mem)
    else $error("L2 miss not forwarded to memory.");

  property p_walk_first;
    @(posedge clk_sys_i) disable iff (rst_i)
    (swpf_ready_o && swpf_valid_i) |=> walk_req_o ##0 !l1_fill_valid_o || !sw_l1_req;
  endproperty
  a_walk_first: assert property (p_walk_first)
    else $error("Software prefetch skipped the walk.");

  property p_hw_suppress;
    @(posedge clk_sys_i) disable iff (rst_i)
    (l1_fill_valid_o && !sw_l1_req) |-> !l1_line_present_i && !(|fb_cand_hit);
  endproperty
  a_hw_suppress: assert property (p_hw_suppress)
    else $error("Redundant hardware prefetch issued.");

  property p_fb_hold;
    @(posedge clk_sys_i) disable iff (rst_i)
    (l1_fire && sw_l1_req) |=> fb_v_ff[$past(fb_free_idx)]
      && fb_line_ff[$past(fb_free_idx)] == $past(sw_line);
  endproperty
  a_fb_hold: assert property (p_fb_hold)
    else $error("Software L1 prefetch got no fill buffer.");

  property p_l2_no_fb;
    @(posedge clk_sys_i) disable iff (rst_i)
    (sw_st_ff == SW_ISSUE && !sw_l1_ff && l1_fill_valid_o) |-> l1_fill_line_o == cand_line_ff;
  endproperty
  a_l2_no_fb: assert property (p_l2_no_fb)
    else $error("Software L2 prefetch took an L1 fill buffer.");
endmodule

// File: hdl/tlhp_pkg.sv
// Constants and types shared by the tile hardware prefetchers.
package tlhp_pkg;
  localparam int PA_W = 40;
  localparam int LINE_OFS = 6;
  localparam int LN_W = PA_W - LINE_OFS;
  localparam int PAGE_OFS = 12;
  localparam int REG_W = PAGE_OFS - LINE_OFS;
  localparam int PG_W = LN_W - REG_W;
  localparam int LP_W = 2;
  localparam int ST_DEPTH = 64;
  localparam int ST_IDX_W = 6;
  localparam int STRIDE_W = 13;
  localparam int CONF_W = 2;
  localparam logic [CONF_W-1:0] CONF_RST = 2'h0;
  localparam logic [CONF_W-1:0] CONF_TRAIN = 2'h2;
  localparam logic [CONF_W-1:0] CONF_MAX = 2'h3;
  localparam int DET_N = 48;
  localparam int DET_IDX_W = 6;
  localparam logic [DET_IDX_W-1:0] DET_PTR_RST = 6'h00;
  localparam logic [DET_IDX_W-1:0] DET_PTR_LAST = 6'h2F;
  localparam logic [REG_W-1:0] REG_TOP = 6'h3F;
  localparam logic [REG_W-1:0] REG_BOT = 6'h00;
  localparam logic [REG_W-1:0] REG_STEP = 6'h01;
  localparam int FB_N = 4;
  localparam int FB_IDX_W = 2;

  typedef struct packed {
    logic [PA_W-1:0] last;
    logic [STRIDE_W-1:0] stride;
    logic [CONF_W-1:0] conf;
  } tlhp_stride_t;

  typedef enum {SW_IDLE, SW_WALK, SW_ISSUE} tlhp_sw_t;
  typedef enum {L2_IDLE, L2_LOOK, L2_WAIT, L2_MEM} tlhp_l2_t;
endpackage

// File: hdl/tlhp_stride_mem.sv
// Stride tracking table storage with a registered read port.
`timescale 1ns/1ps
module tlhp_stride_mem
  import tlhp_pkg::*;
#(
  parameter int W = $bits(tlhp_stride_t),
  parameter int D = ST_DEPTH,
  parameter int AW = ST_IDX_W
)
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Read port
  input wire logic [AW-1:0] rd_idx_i,
  output logic [W-1:0] rd_data_o,
  // Write port
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_idx_i,
  input wire logic [W-1:0] wr_data_i
);
  logic [W-1:0] mem_ff [D];

  // Contents carry no reset; validity is tracked beside the array.
  always_ff @(posedge clk_sys_i)
  begin
    if (wr_en_i)
    begin
      mem_ff[wr_idx_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      rd_data_o <= '0;
    else
      rd_data_o <= mem_ff[rd_idx_i];
  end
endmodule

// File: test/tlhp_far_model.sv
// Behavioural far side of the prefetchers: L1, L2, memory and page table walker.
`timescale 1ns/1ps
module tlhp_far_model
  import tlhp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Behaviour controls
  input wire logic pres_en_i,
  input wire logic miss_en_i,
  input wire logic [3:0] lat_i,
  input wire logic [7:0] done_lat_i,
  // L1 side
  input wire logic [LN_W-1:0] l1_probe_line_i,
  output logic l1_line_present_o,
  input wire logic l1_fill_valid_i,
  input wire logic [LN_W-1:0] l1_fill_line_i,
  output logic l1_fill_ready_o,
  output logic l1_fill_done_o,
  output logic [LN_W-1:0] l1_fill_done_line_o,
  // L2, memory and walker side
  input wire logic l2_pf_valid_i,
  output logic l2_pf_ready_o,
  output logic l2_resp_valid_o,
  output logic l2_resp_miss_o,
  input wire logic mem_pf_valid_i,
  output logic mem_pf_ready_o,
  input wire logic walk_req_i,
  output logic walk_done_o
);
  logic [3:0] f_cnt_ff;
  logic [3:0] l_cnt_ff;
  logic [3:0] m_cnt_ff;
  logic [3:0] w_cnt_ff;
  logic [1:0] resp_sr_ff;
  logic done_ff;
  logic [LN_W-1:0] done_last_ff;
  int unsigned cyc;
  int unsigned due_q[$];
  logic [LN_W-1:0] line_q[$];

  // A released line shows the inverse of its last value, so stale data never looks valid.
  assign l1_line_present_o = pres_en_i && (l1_probe_line_i === l1_probe_line_i);
  assign l1_fill_ready_o = l1_fill_valid_i && (f_cnt_ff >= lat_i);
  assign l2_pf_ready_o = l2_pf_valid_i && (l_cnt_ff >= lat_i);
  assign mem_pf_ready_o = mem_pf_valid_i && (m_cnt_ff >= lat_i);
  assign walk_done_o = walk_req_i && (w_cnt_ff == 4'h3);
  assign l2_resp_valid_o = resp_sr_ff[1];
  assign l2_resp_miss_o = resp_sr_ff[1] ? miss_en_i : ~miss_en_i;
  assign l1_fill_done_o = done_ff;
  assign l1_fill_done_line_o = done_ff ? done_last_ff : ~done_last_ff;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      f_cnt_ff <= 4'h0;
      l_cnt_ff <= 4'h0;
      m_cnt_ff <= 4'h0;
      w_cnt_ff <= 4'h0;
      resp_sr_ff <= 2'h0;
    end
    else
    begin
      f_cnt_ff <= (l1_fill_valid_i && !l1_fill_ready_o) ? f_cnt_ff + 4'h1 : 4'h0;
      l_cnt_ff <= (l2_pf_valid_i && !l2_pf_ready_o) ? l_cnt_ff + 4'h1 : 4'h0;
      m_cnt_ff <= (mem_pf_valid_i && !mem_pf_ready_o) ? m_cnt_ff + 4'h1 : 4'h0;
      w_cnt_ff <= walk_req_i ? w_cnt_ff + 4'h1 : 4'h0;
      resp_sr_ff <= {resp_sr_ff[0], l2_pf_valid_i && l2_pf_ready_o};
    end
  end

  // Fills complete in order after the latency set by done_lat_i, one pulse per accepted request.
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cyc = 0;
      due_q.delete();
      line_q.delete();
      done_ff <= 1'b0;
      done_last_ff <= '0;
    end
    else
    begin
      cyc = cyc + 1;
      if (l1_fill_valid_i && l1_fill_ready_o)
      begin
        due_q.push_back(cyc + done_lat_i);
        line_q.push_back(l1_fill_line_i);
      end
      done_ff <= 1'b0;
      if (due_q.size() > 0 && due_q[0] <= cyc)
      begin
        done_ff <= 1'b1;
        done_last_ff <= line_q.pop_front();
        void'(due_q.pop_front());
      end
    end
  end
endmodule

// File: test/tlhp_top_tb.sv
// Self-checking bench for the tile prefetchers against the behavioural far side.
`timescale 1ns/1ps
module tlhp_top_tb
  import tlhp_pkg::*;
  ;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic acc_valid_i = 1'b0;
  logic [PA_W-1:0] acc_addr_i = '0;
  logic [PA_W-1:0] acc_ip_i = '0;
  logic [LP_W-1:0] acc_lp_i = '0;
  logic acc_cacheable_i = 1'b0;
  logic l2_acc_valid_i = 1'b0;
  logic [LN_W-1:0] l2_acc_line_i = '0;
  logic swpf_valid_i = 1'b0;
  logic [PA_W-1:0] swpf_addr_i = '0;
  logic swpf_l1_i = 1'b0;
  logic pres_en = 1'b0;
  logic miss_en = 1'b0;
  logic [3:0] lat = 4'h0;
  logic [7:0] done_lat = 8'h04;
  logic [LN_W-1:0] l1_probe_line_o;
  logic l1_line_present_i;
  logic l1_fill_valid_o;
  logic [LN_W-1:0] l1_fill_line_o;
  logic l1_fill_ready_i;
  logic l1_fill_done_i;
  logic [LN_W-1:0] l1_fill_done_line_i;
  logic l2_pf_valid_o;
  logic [LN_W-1:0] l2_pf_line_o;
  logic l2_pf_ready_i;
  logic l2_resp_valid_i;
  logic l2_resp_miss_i;
  logic mem_pf_valid_o;
  logic [LN_W-1:0] mem_pf_line_o;
  logic mem_pf_ready_i;
  logic swpf_ready_o;
  logic walk_req_o;
  logic [PA_W-1:0] walk_addr_o;
  logic walk_done_i;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  tlhp_top i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .acc_valid_i(acc_valid_i),
    .acc_addr_i(acc_addr_i), .acc_ip_i(acc_ip_i), .acc_lp_i(acc_lp_i),
    .acc_cacheable_i(acc_cacheable_i), .l2_acc_valid_i(l2_acc_valid_i),
    .l2_acc_line_i(l2_acc_line_i), .l1_probe_line_o(l1_probe_line_o),
    .l1_line_present_i(l1_line_present_i), .l1_fill_valid_o(l1_fill_valid_o),
    .l1_fill_line_o(l1_fill_line_o), .l1_fill_ready_i(l1_fill_ready_i),
    .l1_fill_done_i(l1_fill_done_i), .l1_fill_done_line_i(l1_fill_done_line_i),
    .l2_pf_valid_o(l2_pf_valid_o), .l2_pf_line_o(l2_pf_line_o), .l2_pf_ready_i(l2_pf_ready_i),
    .l2_resp_valid_i(l2_resp_valid_i), .l2_resp_miss_i(l2_resp_miss_i),
    .mem_pf_valid_o(mem_pf_valid_o), .mem_pf_line_o(mem_pf_line_o),
    .mem_pf_ready_i(mem_pf_ready_i), .swpf_valid_i(swpf_valid_i), .swpf_addr_i(swpf_addr_i),
    .swpf_l1_i(swpf_l1_i), .swpf_ready_o(swpf_ready_o), .walk_req_o(walk_req_o),
    .walk_addr_o(walk_addr_o), .walk_done_i(walk_done_i));

  tlhp_far_model i_far (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .pres_en_i(pres_en),
    .miss_en_i(miss_en), .lat_i(lat), .done_lat_i(done_lat), .l1_probe_line_i(l1_probe_line_o),
    .l1_line_present_o(l1_line_present_i), .l1_fill_valid_i(l1_fill_valid_o),
    .l1_fill_line_i(l1_fill_line_o), .l1_fill_ready_o(l1_fill_ready_i),
    .l1_fill_done_o(l1_fill_done_i), .l1_fill_done_line_o(l1_fill_done_line_i),
    .l2_pf_valid_i(l2_pf_valid_o), .l2_pf_ready_o(l2_pf_ready_i),
    .l2_resp_valid_o(l2_resp_valid_i), .l2_resp_miss_o(l2_resp_miss_i),
    .mem_pf_valid_i(mem_pf_valid_o), .mem_pf_ready_o(mem_pf_ready_i),
    .walk_req_i(walk_req_o), .walk_done_o(walk_done_i));

  // ----------------------------------------------------------------
  // Drivers and comparisons
  // ----------------------------------------------------------------
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
      n_mismatch++;
    end
  endtask

  task automatic cmp_line(input string what, input logic [PA_W-1:0] exp,
                          input logic [PA_W-1:0] got);
    compares++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
      n_mismatch++;
    end
  endtask

  // Port 0 is the L1 fill, 1 the L2 lookup, 2 the memory request, 3 the walker.
  task automatic expect_req(input string what, input int sel, input int cyc, input logic exp_hit,
                            input logic [PA_W-1:0] exp_val);
    logic hit;
    logic [PA_W-1:0] val;
    int n;
    hit = 1'b0;
    val = '0;
    n = 0;
    while (hit !== 1'b1 && n < cyc)
    begin
      @(posedge clk_sys_i);
      #1;
      n++;
      hit = (sel == 0) ? (l1_fill_valid_o && l1_fill_ready_i) :
            (sel == 1) ? (l2_pf_valid_o && l2_pf_ready_i) :
            (sel == 2) ? (mem_pf_valid_o && mem_pf_ready_i) : walk_req_o;
      val = (sel == 0) ? PA_W'(l1_fill_line_o) : (sel == 1) ? PA_W'(l2_pf_line_o) :
            (sel == 2) ? PA_W'(mem_pf_line_o) : walk_addr_o;
    end
    @(posedge clk_sys_i);
    #1;
    cmp_bit(what, exp_hit, hit);
    if (exp_hit && hit === 1'b1)
      cmp_line(what, exp_val, val);
  endtask

  task automatic put_acc(input logic [PA_W-1:0] a, input logic [PA_W-1:0] ip,
                         input logic [LP_W-1:0] lp, input logic c);
    @(posedge clk_sys_i);
    #1;
    acc_valid_i = 1'b1;
    acc_addr_i = a;
    acc_ip_i = ip;
    acc_lp_i = lp;
    acc_cacheable_i = c;
  endtask

  task automatic put_l2(input logic [LN_W-1:0] ln);
    @(posedge clk_sys_i);
    #1;
    l2_acc_valid_i = 1'b1;
    l2_acc_line_i = ln;
  endtask

  task automatic idle;
    @(posedge clk_sys_i);
    #1;
    acc_valid_i = 1'b0;
    acc_addr_i = ~acc_addr_i;
    l2_acc_valid_i = 1'b0;
    l2_acc_line_i = ~l2_acc_line_i;
  endtask

  task automatic stride3(input logic [PA_W-1:0] a, input logic [PA_W-1:0] s,
                         input logic [PA_W-1:0] ip, input logic c);
    for (int k = 0; k < 4; k++)
      put_acc(a + s * k, ip, 2'h0, c);
    idle();
  endtask

  task automatic sw_req(input logic [PA_W-1:0] a, input logic to_l1);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    #1;
    swpf_valid_i = 1'b1;
    swpf_addr_i = a;
    swpf_l1_i = to_l1;
    while (swpf_ready_o !== 1'b1 && n < 50)
    begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    @(posedge clk_sys_i);
    #1;
    swpf_valid_i = 1'b0;
    swpf_addr_i = ~a;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_stride;
    logic [PA_W-1:0] a;
    a = 40'h0012345000;
    stride3(a, 40'h100, 40'h0000400001, 1'b1);
    expect_req("stride fill", 0, 8, 1'b1, (a + 40'h400) >> LINE_OFS);
    pres_en = 1'b1;
    stride3(a + 40'h10000, 40'h100, 40'h0000400002, 1'b1);
    expect_req("present line", 0, 8, 1'b0, '0);
    pres_en = 1'b0;
    stride3(40'h0012346C00, 40'h100, 40'h0000400003, 1'b1);
    expect_req("page crossing", 0, 8, 1'b0, '0);
    stride3(40'h0012347000, 40'h40, 40'h0000400004, 1'b0);
    expect_req("uncached page", 0, 8, 1'b0, '0);
    for (int k = 0; k < 4; k++)
      put_acc(40'h0012348000 + 40'h80 * k, 40'h0000400005, LP_W'(k % 2), 1'b1);
    idle();
    expect_req("per thread entry", 0, 8, 1'b0, '0);
  endtask

  task automatic t_stream;
    logic [LN_W-1:0] base;
    logic [LN_W-1:0] nxt;
    int step;
    lat = 4'h2;
    for (int k = 0; k < 4; k++)
    begin
      step = (k == 1) ? -1 : (k == 3) ? 2 : 1;
      base = {28'h00ABC00 + 28'(k), (k == 1) ? 6'h20 : (k == 2) ? 6'h3D : 6'h10};
      miss_en = (k == 0);
      for (int j = 0; j < 3; j++)
        put_l2(base + LN_W'(step * j));
      idle();
      nxt = base + LN_W'(step * 3);
      expect_req("stream lookup", 1, 10, k < 2, PA_W'(nxt));
      if (k == 0)
        expect_req("memory request", 2, 12, 1'b1, PA_W'(nxt));
      repeat (6) @(posedge clk_sys_i);
    end
    miss_en = 1'b0;
  endtask

  task automatic t_pool;
    logic [LN_W-1:0] r0;
    for (int n = 47; n < 49; n++)
    begin
      r0 = {28'h0BEEF00 + 28'(n), 6'h08};
      put_l2(r0);
      for (int j = 0; j < n; j++)
        put_l2({28'h0C00000 + 28'(n * 64 + j), 6'h00});
      put_l2(r0 + 34'h1);
      put_l2(r0 + 34'h2);
      idle();
      expect_req("detector pool", 1, 10, n == 47, PA_W'(r0 + 34'h3));
      repeat (6) @(posedge clk_sys_i);
    end
    lat = 4'h1;
  endtask

  task automatic t_swpf;
    logic [PA_W-1:0] a;
    done_lat = 8'd90;
    for (int k = 0; k < 6; k++)
    begin
      a = 40'h0055500040 + 40'h1000 * k;
      sw_req(a, k != 4);
      expect_req("walk request", 3, 8, 1'b1, a);
      if (k == 4)
        expect_req("L2 software prefetch", 1, 15, 1'b1, a >> LINE_OFS);
      else if (k == 5)
        expect_req("fill buffers full", 0, 10, 1'b0, '0);
      else
        expect_req("L1 software fill", 0, 10, 1'b1, a >> LINE_OFS);
    end
    expect_req("fill after release", 0, 100, 1'b1, 40'h0055505040 >> LINE_OFS);
    done_lat = 8'd4;
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // The whole run needs well under two thousand cycles.
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (5) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    t_stride();
    t_stream();
    t_pool();
    t_swpf();
    wrap_up();
  end
endmodule
